//--- shared/pslice_pkg.sv
// Constants for the pattern-match bit-slice source select block.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz aclk.
package pslice_pkg;

  // ==========================================================
  // Register addresses (byte addresses, full 32 bits)
  localparam logic [31:0] PATTERN_CONTROL_ADDR     = 32'h4001_8028;
  localparam logic [31:0] SLICE_SOURCE_SELECT_ADDR = 32'h4001_802c;
  localparam logic [31:0] SLICE_CONFIGURATION_ADDR = 32'h4001_8030;
  localparam logic [31:0] SLICE_STATUS_ADDR        = 32'h4001_8034;

  // ==========================================================
  // Field layout
  localparam int          NUM_SLICES        = 8;
  localparam int          SRC_WIDTH         = 3;
  localparam int          SLICE0_LSB        = 8;
  localparam int          SLICE1_LSB        = 11;
  localparam int          SLICE2_LSB        = 14;
  localparam int          SLICE3_LSB        = 17;
  localparam int          SLICE4_LSB        = 20;
  localparam int          SLICE5_LSB        = 23;
  localparam int          SLICE6_LSB        = 26;
  localparam int          SLICE7_LSB        = 29;
  localparam int          MODE_SELECT_BIT   = 0;
  localparam int          EVENT_ENABLE_BIT  = 1;
  localparam int          MATCH_STATE_LSB   = 24;
  localparam int          STATUS_RISE_LSB   = 8;
  localparam int          STATUS_FALL_LSB   = 16;
  // Low byte of the source register is reserved
  localparam logic [31:0] SRC_WRITE_MASK    = 32'hffff_ff00;
  localparam logic [31:0] CTRL_WRITE_MASK   = 32'h0000_0003;

  // ==========================================================
  // Values after reset
  localparam logic [31:0] SRC_RESET         = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET         = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // ==========================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage : pslice_pkg

//--- src/slice_history.sv
// Edge-detect history of the eight bit slices.
// Assumes slice_in is already synchronous to aclk.
`timescale 1ns/1ps
module slice_history
  import pslice_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic                  clear,
  input  wire logic [NUM_SLICES-1:0] slice_in,
  output logic      [NUM_SLICES-1:0] level_q,
  output logic      [NUM_SLICES-1:0] rise_q,
  output logic      [NUM_SLICES-1:0] fall_q
);

  logic [NUM_SLICES-1:0] level_d;
  logic [NUM_SLICES-1:0] rise_d;
  logic [NUM_SLICES-1:0] fall_d;

  // ==========================================================
  // History update
  always_comb begin
    level_d = slice_in;
    // New edges win over a clear in the same cycle; the clear
    // leaves the level, which reloads every cycle, so no false edge follows it
    rise_d  = (rise_q & ~{NUM_SLICES{clear}}) | (slice_in & ~level_q);
    fall_d  = (fall_q & ~{NUM_SLICES{clear}}) | (~slice_in & level_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= '0;
      rise_q  <= '0;
      fall_q  <= '0;
    end else if (ce) begin
      level_q <= level_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

endmodule : slice_history

//--- src/pattern_slice_source_select.sv
// Source select register bank for the pattern-match bit slices.
// Assumes an AXI4-Lite master on aclk and asynchronous pin inputs.
// How it works
// - Eight bit slices each take one of eight pin inputs via a 3-bit field.
// - Field value n routes synchronised pin input n to that slice.
// - Slice 0 selector sits at bits 10:8 and resets to zero.
// - Slice 1 selector sits at bits 13:11 and resets to zero.
// - Slice 2 selector sits at bits 16:14 and resets to zero.
// - Slice 3 selector sits at bits 19:17 and resets to zero.
// - Slice 4 selector sits at bits 22:20 and resets to zero.
// - Any write to the source or configuration register wipes history.
// - Clearing both mode select and event enable also wipes history.
// - Slices 5, 6, 7 sit at bits 25:23, 28:26, 31:29, reset to zero.
// - Mode select 1 drives irq from pattern matches, 0 from pin irqs.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module pattern_slice_source_select
  import pslice_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [NUM_SLICES-1:0] pin_in,
  input  wire logic [NUM_SLICES-1:0] pin_irq_in,
  input  wire logic [NUM_SLICES-1:0] pattern_match_in,
  output logic      [NUM_SLICES-1:0] slice_input,
  output logic      [NUM_SLICES-1:0] slice_rise,
  output logic      [NUM_SLICES-1:0] slice_fall,
  output logic      [31:0]           slice_configuration,
  output logic      [NUM_SLICES-1:0] irq,
  output logic                       cpu_wake_event
);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = data[b*8 +: 8];
    end
    return res;
  endfunction : merge_strb
  // Picks the pin input named by a 3-bit source field
  function automatic logic pick(input logic [NUM_SLICES-1:0] pins,
                                input logic [31:0]           src,
                                input int                    lsb);
    logic [SRC_WIDTH-1:0] sel;
    sel = src[lsb +: SRC_WIDTH];
    return pins[sel];
  endfunction : pick
  // ==========================================================
  // Pin synchronisers: a change counts once stages 2 and 3 agree
  logic [NUM_SLICES-1:0] sync1_q, sync2_q, sync3_q;
  logic [NUM_SLICES-1:0] pin_q, pin_d;
  always_comb pin_d = ((sync2_q ~^ sync3_q) & sync3_q)
                    | ((sync2_q ^ sync3_q) & pin_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sync1_q, sync2_q, sync3_q, pin_q} <= '0;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q   <= pin_d;
    end
  end
  // ==========================================================
  // Write channel: address and data taken in either order
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [31:0] aw_addr_q, aw_addr_d, w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, do_write;
  logic [1:0]  bresp_q, bresp_d;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      unique case (aw_addr_q)
        PATTERN_CONTROL_ADDR,
        SLICE_SOURCE_SELECT_ADDR,
        SLICE_CONFIGURATION_ADDR: bresp_d = RESP_OKAY;
        default:                  bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_hold_d;
    wready_d  = !w_hold_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end
  // ==========================================================
  // Registers
  logic [31:0] src_q, src_d;
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic        hist_clear_q, hist_clear_d;
  always_comb begin
    src_d        = src_q;
    cfg_d        = cfg_q;
    ctrl_d       = ctrl_q;
    hist_clear_d = 1'b0;
    if (do_write) begin
      unique case (aw_addr_q)
        SLICE_SOURCE_SELECT_ADDR: begin
          // Reserved low byte is never stored
          src_d = merge_strb(src_q, w_data_q, w_strb_q)
                  & SRC_WRITE_MASK;
          hist_clear_d = 1'b1;
        end
        SLICE_CONFIGURATION_ADDR: begin
          cfg_d        = merge_strb(cfg_q, w_data_q, w_strb_q);
          hist_clear_d = 1'b1;
        end
        PATTERN_CONTROL_ADDR: begin
          ctrl_d = merge_strb(ctrl_q, w_data_q, w_strb_q)
                   & CTRL_WRITE_MASK;
        end
        default: src_d = src_q;
      endcase
    end
    // Held cleared for as long as the feature stays disabled
    if (!ctrl_q[MODE_SELECT_BIT] && !ctrl_q[EVENT_ENABLE_BIT]) begin
      hist_clear_d = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q        <= SRC_RESET;
      cfg_q        <= CFG_RESET;
      ctrl_q       <= CTRL_RESET;
      hist_clear_q <= 1'b1;
    end else if (ce) begin
      src_q        <= src_d;
      cfg_q        <= cfg_d;
      ctrl_q       <= ctrl_d;
      hist_clear_q <= hist_clear_d;
    end
  end
  // ==========================================================
  // Slice routing and outputs
  logic [NUM_SLICES-1:0] slice_q, slice_d;
  logic [NUM_SLICES-1:0] irq_q, irq_d;
  logic                  wake_q, wake_d;
  always_comb begin
    // One selector per slice, value n picks pin input n
    slice_d[0] = pick(pin_q, src_q, SLICE0_LSB);
    slice_d[1] = pick(pin_q, src_q, SLICE1_LSB);
    slice_d[2] = pick(pin_q, src_q, SLICE2_LSB);
    slice_d[3] = pick(pin_q, src_q, SLICE3_LSB);
    slice_d[4] = pick(pin_q, src_q, SLICE4_LSB);
    slice_d[5] = pick(pin_q, src_q, SLICE5_LSB);
    slice_d[6] = pick(pin_q, src_q, SLICE6_LSB);
    slice_d[7] = pick(pin_q, src_q, SLICE7_LSB);
    irq_d  = ctrl_q[MODE_SELECT_BIT] ? pattern_match_in
                                     : pin_irq_in;
    wake_d = ctrl_q[EVENT_ENABLE_BIT] && (|pattern_match_in);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slice_q <= '0;
      irq_q   <= '0;
      wake_q  <= 1'b0;
    end else if (ce) begin
      slice_q <= slice_d;
      irq_q   <= irq_d;
      wake_q  <= wake_d;
    end
  end
  // Slice level tracks slice_q one cycle later
  slice_history u_history (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .clear    (hist_clear_q),
    .slice_in (slice_q),
    .level_q  (slice_input),
    .rise_q   (slice_rise),
    .fall_q   (slice_fall)
  );
  // ==========================================================
  // Read channel: answer one cycle after the address is taken
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  always_comb begin
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (s_axi_araddr)
        PATTERN_CONTROL_ADDR: begin
          rdata_d = ctrl_q;
          rdata_d[MATCH_STATE_LSB +: NUM_SLICES] = pattern_match_in;
        end
        SLICE_SOURCE_SELECT_ADDR: rdata_d = src_q;
        SLICE_CONFIGURATION_ADDR: rdata_d = cfg_q;
        SLICE_STATUS_ADDR: begin
          rdata_d = '0;
          rdata_d[NUM_SLICES-1:0]                     = slice_input;
          rdata_d[STATUS_RISE_LSB +: NUM_SLICES] = slice_rise;
          rdata_d[STATUS_FALL_LSB +: NUM_SLICES] = slice_fall;
        end
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end
  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign slice_configuration = cfg_q;
  assign irq                 = irq_q;
  assign cpu_wake_event      = wake_q;
endmodule : pattern_slice_source_select

//--- tb/pslice_monitor.sv
// Port-level checks for the slice source select block.
// Assumes it is bound to that block; single aclk domain.
`timescale 1ns/1ps
module pslice_monitor
  import pslice_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  pin_irq_in,
  input wire logic [7:0]  pattern_match_in,
  input wire logic [7:0]  slice_rise,
  input wire logic [7:0]  slice_fall,
  input wire logic [7:0]  irq,
  input wire logic        cpu_wake_event
);
  // ==========================================================
  // Read address tracking
  logic [31:0] addr_d, addr_q;
  logic        mapped;
  always_comb begin
    addr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : addr_q;
  end
  always_ff @(posedge aclk) begin
    addr_q <= addr_d;
  end
  assign mapped = addr_q inside {PATTERN_CONTROL_ADDR,
    SLICE_SOURCE_SELECT_ADDR, SLICE_CONFIGURATION_ADDR, SLICE_STATUS_ADDR};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Assertions
  chk_irq_source: assert property (
    1'b1 |=> irq == $past(pin_irq_in) || irq == $past(pattern_match_in))
    else $error("irq follows neither source");
  chk_wake_cause: assert property (
    cpu_wake_event |-> $past(pattern_match_in) != 8'h00)
    else $error("wake event without a match");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_src_low_zero: assert property (
    s_axi_rvalid && addr_q == SLICE_SOURCE_SELECT_ADDR
    |-> s_axi_rdata[7:0] == 8'h00 && s_axi_rresp == RESP_OKAY)
    else $error("source low byte not zero");
  chk_unmapped_read: assert property (
    s_axi_rvalid && !mapped |-> s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // Assumes address and data are offered together, as the bench does
  chk_history_wipe: assert property (
    s_axi_awvalid && s_axi_awready && (s_axi_awaddr ==
    SLICE_SOURCE_SELECT_ADDR || s_axi_awaddr == SLICE_CONFIGURATION_ADDR)
    |-> ##[1:6] slice_rise == 8'h00 && slice_fall == 8'h00)
    else $error("history not wiped by write");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_wake: cover property (cpu_wake_event);
endmodule : pslice_monitor

bind pattern_slice_source_select pslice_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_irq_in(pin_irq_in), .pattern_match_in(pattern_match_in),
  .slice_rise(slice_rise), .slice_fall(slice_fall), .irq(irq),
  .cpu_wake_event(cpu_wake_event));

//--- tb/test_pattern_slice_source_select.sv
// Self-checking bench for the slice source select block.
// Assumes a 100 MHz aclk; the bench is the only AXI4-Lite master.
`timescale 1ns/1ps
module test_pattern_slice_source_select
  import pslice_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, cpu_wake_event;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, slice_configuration, w;
  logic [7:0]  pin_in = '0, pin_irq_in = '0, pattern_match_in = '0;
  logic [7:0]  slice_input, slice_rise, slice_fall, irq, ex;
  int          bad_count = 0, n_tests = 0, cycles = 0;

  pattern_slice_source_select dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_in(pin_in),
    .pin_irq_in(pin_irq_in), .pattern_match_in(pattern_match_in),
    .slice_input(slice_input), .slice_rise(slice_rise),
    .slice_fall(slice_fall), .slice_configuration(slice_configuration),
    .irq(irq), .cpu_wake_event(cpu_wake_event));

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Returns on an edge so that the next stimulus is an edge write
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    // Ready is raised late on purpose so bvalid must stand
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    chk($sformatf("rdata %h", a), e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask : rd

  // ==========================================================
  // Clock, timeout and sequence
  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    rd(SLICE_SOURCE_SELECT_ADDR,
       SRC_RESET, RESP_OKAY);
    rd(SLICE_CONFIGURATION_ADDR, CFG_RESET, RESP_OKAY);
    rd(PATTERN_CONTROL_ADDR, CTRL_RESET, RESP_OKAY);
    // Every slice gets every code once, each slice a different one
    for (int n = 0; n < 8; n++) begin
      w = 32'h0;
      for (int k = 0; k < 8; k++) w[SLICE0_LSB + 3 * k +: 3] = 3'((k + n) % 8);
      pin_in <= 8'h35 ^ 8'(n * 17);
      wr(SLICE_SOURCE_SELECT_ADDR, w, RESP_OKAY);
      tick(12);
      rd(SLICE_SOURCE_SELECT_ADDR, w, RESP_OKAY);
      for (int k = 0; k < 8; k++) ex[k] = pin_in[(k + n) % 8];
      chk("slice_input", {24'h0, ex}, {24'h0, slice_input});
    end
    wr(SLICE_SOURCE_SELECT_ADDR, 32'h0, RESP_OKAY);
    pin_in <= 8'h00;
    wr(PATTERN_CONTROL_ADDR, 32'h3, RESP_OKAY);
    tick(12);
    pin_in <= 8'h01;
    tick(12);
    chk("rise", 32'hff, {24'h0, slice_rise});
    // Status: levels high, rises seen, falls wiped while disabled
    rd(SLICE_STATUS_ADDR, 32'h0000_ffff, RESP_OKAY);
    wr(SLICE_SOURCE_SELECT_ADDR, 32'h0, RESP_OKAY);
    tick(3);
    chk("rise", 32'h0, {24'h0, slice_rise});
    pin_in <= 8'h00;
    tick(12);
    chk("fall", 32'hff, {24'h0, slice_fall});
    wr(SLICE_CONFIGURATION_ADDR, 32'h1234_5678, RESP_OKAY);
    tick(3);
    chk("fall", 32'h0, {24'h0, slice_fall});
    chk("cfg", 32'h1234_5678, slice_configuration);
    pin_in <= 8'h01;
    tick(12);
    // One control bit left set keeps the history
    wr(PATTERN_CONTROL_ADDR, 32'h2, RESP_OKAY);
    tick(3);
    chk("rise", 32'hff, {24'h0, slice_rise});
    wr(PATTERN_CONTROL_ADDR, 32'h0, RESP_OKAY);
    tick(3);
    chk("rise", 32'h0, {24'h0, slice_rise});
    pattern_match_in <= 8'ha5;
    pin_irq_in <= 8'h3c;
    wr(PATTERN_CONTROL_ADDR, 32'h1, RESP_OKAY);
    tick(3);
    chk("irq", 32'ha5, {24'h0, irq});
    chk("wake", 32'h0, {31'h0, cpu_wake_event});
    rd(PATTERN_CONTROL_ADDR, 32'ha500_0001, RESP_OKAY);
    wr(PATTERN_CONTROL_ADDR, 32'h2, RESP_OKAY);
    tick(3);
    chk("irq", 32'h3c, {24'h0, irq});
    chk("wake", 32'h1, {31'h0, cpu_wake_event});
    // A low enable freezes every stage, the synchronisers too
    ce <= 1'b0;
    pin_in <= 8'h00;
    tick(12);
    chk("frozen", 32'hff, {24'h0, slice_input});
    ce <= 1'b1;
    tick(12);
    chk("thawed", 32'h0, {24'h0, slice_input});
    wr(32'h4001_8040, 32'h1, RESP_SLVERR);
    rd(32'h4001_8040, 32'h0, RESP_SLVERR);
    report_and_stop();
  end
endmodule : test_pattern_slice_source_select
